// ---- rtl/diag_adc_command_decoder.sv ----
// Command decoder for the diagnostic converter configuration register.
// Assumes register writes, key-code writes and converter handshakes all
// arrive from logic on core_clk, so none of them is synchronised here.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RQ1] Cmd 010: key sequencer on iff arg 001
// [RQ2] Cmd 011: auto sequencer on iff arg 001
// [RQ3] Cmd 100: one conversion, stops auto sequencing
// [RQ4] Cmd 101: arm conversions started by key code
// [RQ5] Software never writes commands 110 or 111
// [RQ6] Argument read from same write's bits 7:5
// [RQ7] Reserved selector codes give zero result
// [RQ8] Codes 00000/00001 route the two die sensors
// [RQ9] Code 00011 needs reference buffer enabled
// [RQ10] Code 00100 routes internal reference
// [RQ11] Codes 01100, 01111-10010 route external pins
// [RQ12] Codes 01101/01110 route sense buffer outputs
// [RQ13] Codes 10100-11111 route supply, ground, buck nodes; code routes 10100-10110 and 11000-11111, 10111 gives zero
// [RQ14] Software never selects the reserved codes
// [RQ15] Cmd 000: depth is arg plus one
// [RQ16] Cmd 001: slot arg records current selector
// [RQ17] Each accepted write acts exactly once
module diag_adc_command_decoder
	import diag_conv_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register write path from the serial interface
	input wire logic reg_wr_en,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	// Key code write path
	input wire logic key_wr_en,
	input wire logic [15:0] key_wdata,
	// Settings held in other registers
	input wire logic ref_buf_en,
	input wire logic [1:0] buck_config2_reg,
	// Converter handshake
	input wire logic conv_done,
	input wire logic [11:0] conv_raw_result,
	output logic conv_start,
	output conv_req_t conv_req,
	// Result and status
	output logic [11:0] conv_result,
	output logic conv_result_valid,
	output logic [15:0] cfg_rdata,
	output logic key_seq_on,
	output logic auto_seq_on,
	output logic key_conv_armed,
	output logic [2:0] seq_depth,
	output logic ppc_buf_en
);

	cfg_fields_t cfg_q;
	cfg_fields_t wr;
	conv_cmd_t cmd;
	logic cfg_wr;
	logic key_hit;
	logic wr_depth;
	logic wr_slot;
	logic wr_key_seq;
	logic wr_auto_seq;
	logic wr_single;
	logic wr_key_arm;
	logic [2:0] depth_q;
	logic [4:0] slot_q [NUM_SLOTS];
	logic key_seq_q;
	logic auto_seq_q;
	logic armed_q;
	seq_state_t state_q;
	seq_state_t state_d;
	logic [2:0] idx_q;
	logic [2:0] idx_d;
	logic single_req;
	logic seq_req;
	logic [4:0] issue_sel;
	logic start_q;
	conv_req_t req_q;
	conv_req_t route_req;
	logic busy_q;
	logic in_flight;
	logic zero_pend_q;
	logic [11:0] result_q;
	logic result_valid_q;

	// Write decode: the register acts once per strobe, on its own fields
	assign cfg_wr = reg_wr_en && (reg_addr == CFG_REG_ADDR); // RQ17
	assign wr = cfg_fields_t'(reg_wdata); // RQ6
	assign cmd = conv_cmd_t'(wr.cmd);
	assign key_hit = key_wr_en && (key_wdata == KEY_CODE);

	// One strobe per command; reserved codes raise none, so they only store
	always_comb begin
		wr_depth = 1'b0;
		wr_slot = 1'b0;
		wr_key_seq = 1'b0;
		wr_auto_seq = 1'b0;
		wr_single = 1'b0;
		wr_key_arm = 1'b0;
		if (cfg_wr) begin
			case (cmd)
				CMD_SET_DEPTH: begin
					wr_depth = 1'b1; // RQ15
				end
				CMD_SET_SLOT: begin
					wr_slot = 1'b1; // RQ16
				end
				CMD_KEY_SEQ: begin
					wr_key_seq = 1'b1; // RQ1
				end
				CMD_AUTO_SEQ: begin
					wr_auto_seq = 1'b1; // RQ2
				end
				CMD_SINGLE: begin
					wr_single = 1'b1; // RQ3
				end
				CMD_KEY_ARM: begin
					wr_key_arm = 1'b1; // RQ4
				end
				default: begin
					// Codes 110 and 111 keep their fields but start nothing
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_q <= cfg_fields_t'(CFG_RESET);
		end else if (cfg_wr) begin
			cfg_q <= wr;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			depth_q <= DEPTH_RESET;
		end else if (wr_depth) begin
			depth_q <= wr.arg; // RQ15
		end
	end

	// Slot table lives in flops so a running sequence can read it freely
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				slot_q[i] <= SLOT_RESET;
			end
		end else if (wr_slot) begin
			slot_q[wr.arg] <= wr.sel; // RQ16
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			key_seq_q <= 1'b0;
		end else if (wr_key_seq) begin
			key_seq_q <= (wr.arg == ARG_ENABLE); // RQ1
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			auto_seq_q <= 1'b0;
		end else if (wr_auto_seq) begin
			auto_seq_q <= (wr.arg == ARG_ENABLE); // RQ2
		end else if (wr_single) begin
			auto_seq_q <= 1'b0; // RQ3
		end
	end

	// Arming stays until reset; commands 110 and 111 change nothing
	always_ff @(posedge core_clk) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (wr_key_arm) begin
			armed_q <= 1'b1; // RQ4
		end
	end

	// Single conversions take priority over the sequencers
	always_comb begin
		single_req = 1'b0;
		if (wr_single) begin
			single_req = 1'b1; // RQ3
		end else if (key_hit && armed_q && !key_seq_q) begin
			single_req = 1'b1; // RQ4
		end
	end

	// Sequencer: auto runs continuously, key mode steps one slot per key
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		seq_req = 1'b0;
		case (state_q)
			SEQ_IDLE: begin
				if (auto_seq_q || (key_seq_q && key_hit)) begin
					state_d = SEQ_ISSUE;
				end
			end
			SEQ_ISSUE: begin
				if (single_req || in_flight) begin
					state_d = SEQ_ISSUE;
				end else if (!auto_seq_q && !key_seq_q) begin
					state_d = SEQ_IDLE;
				end else begin
					seq_req = 1'b1;
					state_d = SEQ_WAIT;
				end
			end
			SEQ_WAIT: begin
				if (conv_done && busy_q) begin
					idx_d = (idx_q == depth_q) ? 3'h0 : idx_q + 3'h1;
					state_d = SEQ_IDLE;
				end
			end
			default: begin
				state_d = SEQ_IDLE;
			end
		endcase
		// Turning both sequencers off rewinds to the first slot
		if (!auto_seq_q && !key_seq_q && state_q != SEQ_WAIT) begin
			idx_d = 3'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= SEQ_IDLE;
			idx_q <= 3'h0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
		end
	end

	// Single conversion uses the selector just written, or the held one
	always_comb begin
		issue_sel = slot_q[idx_q];
		if (single_req) begin
			issue_sel = (cfg_wr) ? wr.sel : cfg_q.sel; // RQ6
		end
	end

	conv_input_route u_route (
		.conv_input_sel(issue_sel),
		.ref_buf_en(ref_buf_en),
		.buck_config2_reg(buck_config2_reg),
		.req(route_req)
	);

	// Busy rises one cycle after a start, so a pending start counts too
	assign in_flight = busy_q || start_q;

	// A single request while busy is dropped: the converter cannot queue
	always_ff @(posedge core_clk) begin
		if (rst) begin
			start_q <= 1'b0;
			req_q <= '0;
		end else begin
			start_q <= (single_req && !in_flight) || seq_req;
			if ((single_req && !in_flight) || seq_req) begin
				req_q <= route_req; // RQ8 RQ9 RQ10 RQ11 RQ12 RQ13
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			busy_q <= 1'b0;
			zero_pend_q <= 1'b0;
		end else if (start_q) begin
			busy_q <= 1'b1;
			zero_pend_q <= req_q.zero_result;
		end else if (conv_done) begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			result_q <= 12'h000;
			result_valid_q <= 1'b0;
		end else begin
			result_valid_q <= conv_done && busy_q;
			if (conv_done && busy_q) begin
				result_q <= zero_pend_q ? 12'h000 : conv_raw_result; // RQ7
			end
		end
	end

	assign conv_start = start_q;
	assign conv_req = req_q;
	assign conv_result = result_q;
	assign conv_result_valid = result_valid_q;
	assign cfg_rdata = cfg_fields_t'(cfg_q);
	assign key_seq_on = key_seq_q;
	assign auto_seq_on = auto_seq_q;
	assign key_conv_armed = armed_q;
	assign seq_depth = depth_q;
	assign ppc_buf_en = cfg_q.ppc_buf_en;

endmodule
`default_nettype wire

// ---- rtl/diag_conv_pkg.sv ----
// Package for the diagnostic converter command decoder.
// Assumes one core clock; all users import the whole package.
package diag_conv_pkg;

	// Register address and field layout of converter_command_config
	localparam logic [4:0] CFG_REG_ADDR = 5'h11;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam int CMD_LSB = 8;
	localparam int CMD_MSB = 10;
	localparam int ARG_LSB = 5;
	localparam int ARG_MSB = 7;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 4;
	localparam int PPC_BUF_BIT = 11;

	// Argument value that turns a sequencer on
	localparam logic [2:0] ARG_ENABLE = 3'h1;
	// Key code that starts an armed single conversion
	localparam logic [15:0] KEY_CODE = 16'h1ADC;
	localparam logic [2:0] DEPTH_RESET = 3'h0;
	localparam logic [4:0] SLOT_RESET = 5'h00;
	localparam int NUM_SLOTS = 8;
	localparam int RESULT_W = 12;

	typedef enum logic [2:0] {
		CMD_SET_DEPTH = 3'b000,
		CMD_SET_SLOT = 3'b001,
		CMD_KEY_SEQ = 3'b010,
		CMD_AUTO_SEQ = 3'b011,
		CMD_SINGLE = 3'b100,
		CMD_KEY_ARM = 3'b101,
		CMD_RSVD6 = 3'b110,
		CMD_RSVD7 = 3'b111
	} conv_cmd_t;

	// Input selector codes with a defined node
	localparam logic [4:0] SEL_MAIN_TEMP = 5'h00;
	localparam logic [4:0] SEL_BUCK_TEMP = 5'h01;
	localparam logic [4:0] SEL_EXT_REF = 5'h03;
	localparam logic [4:0] SEL_INT_REF = 5'h04;
	localparam logic [4:0] SEL_PIN2_BIPOLAR = 5'h0C;
	localparam logic [4:0] SEL_SENSE_POS = 5'h0D;
	localparam logic [4:0] SEL_SENSE_NEG = 5'h0E;
	localparam logic [4:0] SEL_PIN1_R0 = 5'h0F;
	localparam logic [4:0] SEL_PIN1_R3 = 5'h12;
	localparam logic [4:0] SEL_SUPPLY_FIRST = 5'h14;
	localparam logic [4:0] SEL_SUPPLY_LAST = 5'h16;
	localparam logic [4:0] SEL_GROUND_FIRST = 5'h18;
	localparam logic [4:0] SEL_BUCK_NODE = 5'h1E;
	localparam logic [4:0] SEL_REF_OUT = 5'h1F;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ISSUE = 2'b01,
		SEQ_WAIT = 2'b10
	} seq_state_t;

	// One conversion request as it goes to the analog mux
	typedef struct packed {
		logic [31:0] route;
		logic zero_result;
		logic [1:0] buck_node;
	} conv_req_t;

	// Fields of one register write
	typedef struct packed {
		logic [3:0] rsvd;
		logic ppc_buf_en;
		logic [2:0] cmd;
		logic [2:0] arg;
		logic [4:0] sel;
	} cfg_fields_t;

endpackage

// ---- rtl/conv_input_route.sv ----
// Maps the input selector code onto a one-hot mux route, or an all-zero route for reserved or unpowered codes.
// Assumes purely combinational use inside the command decoder.
`timescale 1ns/1ps
`default_nettype none
module conv_input_route
	import diag_conv_pkg::*;
(
	// Selection
	input wire logic [4:0] conv_input_sel,
	input wire logic ref_buf_en,
	input wire logic [1:0] buck_config2_reg,
	// Route
	output conv_req_t req
);

	logic defined;

	always_comb begin
		defined = 1'b0;
		case (conv_input_sel)
			SEL_MAIN_TEMP, SEL_BUCK_TEMP, SEL_INT_REF: defined = 1'b1; // RQ8 RQ10
			SEL_EXT_REF: defined = ref_buf_en; // RQ9
			SEL_SENSE_POS, SEL_SENSE_NEG: defined = 1'b1; // RQ12
			SEL_BUCK_NODE, SEL_REF_OUT: defined = 1'b1; // RQ13
			default: begin
				// Pin ranges and supply/ground block are contiguous runs
				if (conv_input_sel == SEL_PIN2_BIPOLAR ||
				    (conv_input_sel >= SEL_PIN1_R0 &&
				     conv_input_sel <= SEL_PIN1_R3)) begin
					defined = 1'b1; // RQ11
				end else if ((conv_input_sel >= SEL_SUPPLY_FIRST &&
				    conv_input_sel <= SEL_SUPPLY_LAST) ||
				    conv_input_sel >= SEL_GROUND_FIRST) begin
					defined = 1'b1; // RQ13
				end
			end
		endcase
	end

	always_comb begin
		req.route = 32'h0000_0000;
		if (defined) begin
			req.route[conv_input_sel] = 1'b1;
		end
		// Reserved or unpowered nodes convert as zero
		req.zero_result = ~defined; // RQ7
		req.buck_node = (conv_input_sel == SEL_BUCK_NODE) ?
			buck_config2_reg : 2'h0; // RQ13
	end

endmodule
`default_nettype wire

// ---- sim/diag_adc_command_checker.sv ----
// Assertion checker for the converter command decoder.
// Assumes it is bound to the decoder top: one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module diag_adc_command_checker
	import diag_conv_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register writes
	input wire logic reg_wr_en,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	// Converter side
	input wire logic conv_done,
	input wire logic conv_start,
	input wire conv_req_t conv_req,
	input wire logic conv_result_valid,
	// Status
	input wire logic [15:0] cfg_rdata,
	input wire logic key_seq_on,
	input wire logic auto_seq_on,
	input wire logic key_conv_armed,
	input wire logic [2:0] seq_depth
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_cmd(logic [2:0] c);
		reg_wr_en && reg_addr == CFG_REG_ADDR &&
			reg_wdata[CMD_MSB:CMD_LSB] == c;
	endsequence
	a_cfg_echo: assert property (reg_wr_en && reg_addr == CFG_REG_ADDR
		|=> cfg_rdata == $past(reg_wdata))
		else $error("config echo wrong");
	a_key_seq_mode: assert property (s_cmd(3'h2) |=>
		key_seq_on == ($past(reg_wdata[ARG_MSB:ARG_LSB]) == ARG_ENABLE))
		else $error("key sequencer mode wrong");
	a_auto_seq_mode: assert property (s_cmd(3'h3) |=>
		auto_seq_on == ($past(reg_wdata[ARG_MSB:ARG_LSB]) == ARG_ENABLE))
		else $error("auto sequencer mode wrong");
	a_single_stops_auto: assert property (s_cmd(3'h4) |=> !auto_seq_on)
		else $error("single did not stop auto");
	a_key_arm_set: assert property (s_cmd(3'h5) |=> key_conv_armed)
		else $error("key arming missing");
	a_depth_load: assert property (s_cmd(3'h0) |=>
		seq_depth == $past(reg_wdata[ARG_MSB:ARG_LSB]))
		else $error("depth not loaded");
	a_route_zero: assert property (conv_start |->
		$onehot0(conv_req.route) &&
		conv_req.zero_result == (conv_req.route == '0))
		else $error("route and zero flag disagree");
	a_start_single: assert property (conv_start |=> !conv_start)
		else $error("start longer than a pulse");
	a_result_cause: assert property (conv_result_valid |->
		$past(conv_done))
		else $error("result without done");
	a_req_holds: assert property (##1 !conv_start |->
		$stable(conv_req))
		else $error("request changed without start");
endmodule
bind diag_adc_command_decoder diag_adc_command_checker chk_u (.core_clk,
	.rst, .reg_wr_en, .reg_addr, .reg_wdata, .conv_done, .conv_start,
	.conv_req, .conv_result_valid, .cfg_rdata, .key_seq_on, .auto_seq_on,
	.key_conv_armed, .seq_depth);
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the converter command decoder.
// Assumes the decoder and its bound checker are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
module tb
	import diag_conv_pkg::*;
;
	logic core_clk, rst, reg_wr_en, key_wr_en, ref_buf_en, conv_done;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, key_wdata, cfg_rdata, last;
	logic [1:0] buck_config2_reg;
	logic [11:0] conv_raw_result, conv_result;
	logic conv_start, conv_result_valid, key_seq_on, auto_seq_on;
	logic key_conv_armed, ppc_buf_en;
	logic [2:0] seq_depth;
	conv_req_t conv_req;
	int bad_count, samples_checked, seed, i;
	logic [31:0] r;
	diag_adc_command_decoder dut_u (.core_clk, .rst, .reg_wr_en,
		.reg_addr, .reg_wdata, .key_wr_en, .key_wdata, .ref_buf_en,
		.buck_config2_reg, .conv_done, .conv_raw_result, .conv_start,
		.conv_req, .conv_result, .conv_result_valid, .cfg_rdata,
		.key_seq_on, .auto_seq_on, .key_conv_armed, .seq_depth,
		.ppc_buf_en);
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Checks the echo and the ppc_buf_en bit after every write, so each write adds two checks
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
		if (a == CFG_REG_ADDR) last = d;
		chk(cfg_rdata, last);
		chk(ppc_buf_en, last[PPC_BUF_BIT]);
	endtask
	function automatic logic [31:0] exp_route(input logic [4:0] s,
		input logic rb);
		if (s inside {5'h00, 5'h01, 5'h04, [5'h0C:5'h12], [5'h14:5'h16],
			[5'h18:5'h1F]} || (s == SEL_EXT_REF && rb)) return 32'h1 << s;
		return 32'h0;
	endfunction
	task automatic done_pulse(input logic [11:0] raw);
		@(negedge core_clk);
		conv_raw_result = raw;
		conv_done = 1'b1;
		@(negedge core_clk);
		conv_done = 1'b0;
	endtask
	// A done with nothing in flight is ignored, so extra pulses are safe
	task automatic drain();
		repeat (3) begin
			done_pulse(12'h000);
			repeat (3) @(negedge core_clk);
		end
	endtask
	task automatic convert(input logic [4:0] s);
		logic [31:0] er;
		logic [11:0] raw;
		r = $random(seed);
		ref_buf_en = r[8];
		buck_config2_reg = r[10:9];
		raw = r[31:20];
		er = exp_route(s, r[8]);
		wr(CFG_REG_ADDR, {4'h0, r[11], CMD_SINGLE, r[7:5], s});
		chk(conv_start, 1'b1);
		chk(conv_req.route, er);
		chk(conv_req.zero_result, er == 32'h0);
		chk(conv_req.buck_node, s == SEL_BUCK_NODE ? r[10:9] : 2'h0);
		done_pulse(raw);
		chk(conv_result_valid, 1'b1);
		chk(conv_result, er == 32'h0 ? 12'h000 : raw);
	endtask
	task automatic key_hit(input logic [15:0] k);
		@(negedge core_clk);
		key_wdata = k;
		key_wr_en = 1'b1;
		@(negedge core_clk);
		key_wr_en = 1'b0;
	endtask
	initial begin
		#1_000_000;
		bad_count++;
		results();
	end
	initial begin
		seed = 32'hdf6f;
		rst = 1'b1;
		reg_wr_en = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		key_wr_en = 1'b0;
		key_wdata = 16'h0000;
		ref_buf_en = 1'b0;
		buck_config2_reg = 2'h0;
		conv_done = 1'b0;
		conv_raw_result = 12'h000;
		last = 16'h0000;
		repeat (6) @(negedge core_clk);
		rst = 1'b0;
		chk({cfg_rdata, key_seq_on, auto_seq_on, seq_depth}, 35'h0);
		for (i = 0; i < 64; i++) begin
			if (!(i[4:0] inside {5'h02, 5'h05, 5'h06, 5'h13}))
				convert(i[4:0]);
		end
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			wr(CFG_REG_ADDR, {5'h00, CMD_SET_DEPTH, i[2:0], r[4:0]});
			chk(seq_depth, i[2:0]);
			wr(CFG_REG_ADDR, {5'h00, CMD_KEY_SEQ, i[2:0], r[9:5]});
			chk(key_seq_on, i == 1);
		end
		wr(CFG_REG_ADDR, {5'h00, CMD_SET_DEPTH, 3'h0, 5'h00});
		wr(CFG_REG_ADDR, {5'h00, CMD_SET_SLOT, 3'h0, SEL_SENSE_NEG});
		wr(CFG_REG_ADDR, {5'h00, CMD_AUTO_SEQ, ARG_ENABLE, 5'h00});
		chk(auto_seq_on, 1'b1);
		i = 0;
		while (!conv_start && i < 10) begin
			@(negedge core_clk);
			i++;
		end
		chk(conv_req.route, 32'h1 << SEL_SENSE_NEG);
		wr(CFG_REG_ADDR, {5'h00, CMD_SINGLE, 3'h0, 5'h00});
		chk(auto_seq_on, 1'b0);
		drain();
		wr(CFG_REG_ADDR, {5'h00, CMD_AUTO_SEQ, ARG_ENABLE, 5'h00});
		wr(CFG_REG_ADDR, {5'h00, CMD_AUTO_SEQ, 3'h5, 5'h00});
		chk(auto_seq_on, 1'b0);
		drain();
		wr(CFG_REG_ADDR, {5'h00, CMD_KEY_ARM, 3'h6, 5'h04});
		chk(key_conv_armed, 1'b1);
		key_hit(KEY_CODE ^ 16'h0001);
		chk(conv_start, 1'b0);
		key_hit(KEY_CODE);
		chk(conv_start, 1'b1);
		chk(conv_req.route, 32'h1 << SEL_INT_REF);
		drain();
		wr(5'h12, 16'hFFFF);
		chk(seq_depth, 3'h0);
		wr(CFG_REG_ADDR, {5'h00, CMD_SET_DEPTH, 3'h1, 5'h00});
		wr(CFG_REG_ADDR, {5'h00, CMD_SET_SLOT, 3'h1, SEL_MAIN_TEMP});
		wr(CFG_REG_ADDR, {5'h00, CMD_KEY_SEQ, ARG_ENABLE, 5'h00});
		chk(key_seq_on, 1'b1);
		// Three key hits walk slot 0, slot 1, then wrap back to slot 0
		for (i = 0; i < 3; i++) begin
			key_hit(KEY_CODE);
			@(negedge core_clk);
			chk(conv_start, 1'b1);
			r = (i == 1) ? 32'h1 << SEL_MAIN_TEMP : 32'h1 << SEL_SENSE_NEG;
			chk(conv_req.route, r);
			done_pulse(12'h000);
		end
		wr(CFG_REG_ADDR, {5'h00, CMD_KEY_SEQ, 3'h0, 5'h00});
		chk(key_seq_on, 1'b0);
		results();
	end
endmodule
`default_nettype wire
